// file: core/spb_pkg.sv
// ============================================================
// shared constants and types for the burst sram port
package spb_pkg;
	localparam int ADDR_W = 17;
	localparam int HI_W = 15;
	localparam int BEAT_W = 2;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int MEM_WORDS = 131072;
	localparam int WBUF_DEPTH = 32;
	localparam int WBUF_W = ADDR_W + LANES + DATA_W;
	localparam logic [LANES-1:0] MASK_ALL = 4'h_F;
	localparam logic [LANES-1:0] MASK_NONE = 4'h_0;
	localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h_0;
	localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h_1;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h_0000_0000;

	// burst operation held between strobes
	typedef enum logic [1:0]
	{
		SPB_OP_IDLE,
		SPB_OP_RD,
		SPB_OP_WR
	} spb_op_t;

	// one sample of every clocked pin
	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic ps_n;
		logic cs_n;
		logic adv_n;
		logic cs1_n;
		logic dhi;
		logic dlo;
		logic gw_n;
		logic bwg_n;
		logic [LANES-1:0] bsel_n;
		logic [DATA_W-1:0] din;
	} spb_in_t;

	localparam spb_in_t IN_RST = '{addr: '0, ps_n: 1'b1, cs_n: 1'b1,
		adv_n: 1'b1, cs1_n: 1'b1, dhi: 1'b0, dlo: 1'b1, gw_n: 1'b1,
		bwg_n: 1'b1, bsel_n: MASK_ALL, din: DATA_RST};
endpackage : spb_pkg

// file: core/spb_wbuf.sv
`timescale 1ns/1ps
// ============================================================
// write buffer: plain synchronous fifo, valid/ready both sides
module spb_wbuf #(
	parameter int WIDTH = 53,
	parameter int DEPTH = 32
)
(
	input wire logic clk_sys, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic in_valid, // entry offered
	output logic in_ready, // room for an entry
	input wire logic [WIDTH-1:0] in_data, // entry to store
	output logic out_valid, // entry available
	input wire logic out_ready, // drain side takes it
	output logic [WIDTH-1:0] out_data // oldest entry
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} spb_wbuf_t;

	spb_wbuf_t s_q;
	spb_wbuf_t s_d;
	logic full;
	logic empty;

	// extra pointer bit tells full from empty
	assign empty = (s_q.wr == s_q.rd);
	assign full = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0])
		&& (s_q.wr[AW] != s_q.rd[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = s_q.mem[s_q.rd[AW-1:0]];

	// push and pop
	always_comb
	begin
		s_d = s_q;
		if (in_valid && !full)
		begin
			s_d.mem[s_q.wr[AW-1:0]] = in_data;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (out_ready && !empty)
			s_d.rd = s_q.rd + 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule : spb_wbuf

// file: core/spb_port.sv
`timescale 1ns/1ps
// Overview of operation
// [RL1] clock samples every pin except output enable, order select, sleep
// [RL2] array of 128K 32-bit words, two-bit counter makes low burst address
// [RL3] either strobe low starts a new access, aborting burst, loading address
// [RL4] controller strobe: selected starts read or write, otherwise deselects
// [RL5] processor strobe ignored with chip select high; otherwise always a read (code deselects when depth selects do not select)
// [RL6] selected only with select1 low, depth high high, depth low low
// [RL7] no strobe: step low advances burst, step high repeats address
// [RL8] order select low: low bits count upward, wrapping modulo four
// [RL9] order select high: low bits are start XOR beat index
// [RL10] floating order select means interleaved; low linear, high interleaved
// [RL11] controller wires the two address low bits to its own LSBs
// [RL12] write when global write low, or gate low with any lane low
// [RL13] global write low writes all four lanes regardless of others
// [RL14] gate low writes only lanes whose select is low
// [RL15] byte-only users hold gate low and global write high
// [RL16] writes are timed inside, from the sampling clock edge
// [RL17] read data goes through output register, out after next edge
// [RL18] bus driven only on reads with output enable low, else floating
// [RL19] controller raises output enable before write after read
// [RL20] sleep: lowest power, internal clock stopped, bus floats, data kept
// [RL21] after sleep ends, stay idle until a strobe starts an access
// [RL22] burst wraps after four beats; upper address bits never change
module spb_port
	import spb_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic [HI_W-1:0] address_in, // upper word address
	input wire logic addr_bit1, // address bit 1
	input wire logic addr_bit0, // address bit 0
	input wire logic processor_addr_strobe_n, // processor strobe
	input wire logic controller_addr_strobe_n, // controller strobe
	input wire logic burst_step_n, // burst advance
	input wire logic chip_select1_n, // main chip enable
	input wire logic depth_select_hi, // depth enable, high active
	input wire logic depth_select_lo, // depth enable, low active
	input wire logic all_byte_write_n, // global write
	input wire logic byte_write_gate_n, // byte write gate
	input wire logic [LANES-1:0] byte_write_select_n, // bit0 lane a
	input wire logic output_enable_n, // async output enable
	input wire logic linear_order_sel, // low linear, high interleaved
	input wire logic sleep_request, // async sleep
	input wire logic [DATA_W-1:0] data_i, // data bus in
	output logic [DATA_W-1:0] data_o, // data bus out
	output logic data_oe_n, // low while driving bus
	output logic write_buf_ready // write buffer has room
);
	// ============================================================
	// state
	typedef struct packed
	{
		spb_in_t inp;
		spb_op_t op;
		logic [HI_W-1:0] addr_hi;
		logic [BEAT_W-1:0] start_lo;
		logic [BEAT_W-1:0] beat;
		logic drive;
	} spb_st_t;

	localparam spb_st_t ST_RST = '{inp: IN_RST, op: SPB_OP_IDLE,
		addr_hi: '0, start_lo: '0, beat: '0, drive: 1'b0};

	spb_st_t s_q;
	spb_st_t s_d;
	logic sel_c;
	logic wr_c;
	logic acc_rd;
	logic acc_wr;
	logic [ADDR_W-1:0] acc_addr;
	logic [BEAT_W-1:0] cur_lo;
	logic [LANES-1:0] wmask;
	logic [DATA_W-1:0] rd_data_q;
	logic [DATA_W-1:0] mem [MEM_WORDS];
	logic buf_out_valid;
	logic buf_out_ready;
	logic [WBUF_W-1:0] buf_out_data;
	logic [ADDR_W-1:0] drain_addr;
	logic [LANES-1:0] drain_mask;
	logic [DATA_W-1:0] drain_data;

	// ============================================================
	// decode helpers
	function automatic logic f_sel(input spb_in_t i);
		return !i.cs1_n && i.dhi && !i.dlo; // see [RL6]
	endfunction : f_sel

	function automatic logic [LANES-1:0] f_mask(input spb_in_t i);
		if (!i.gw_n)
			return MASK_ALL; // see [RL13]
		else if (!i.bwg_n)
			return ~i.bsel_n; // see [RL14]
		else
			return MASK_NONE;
	endfunction : f_mask

	// pin low counts up, pin high xors the beat in
	// a floating pin is pulled high on the board: interleaved, see [RL10]
	function automatic logic [BEAT_W-1:0] f_lo(
		input logic [BEAT_W-1:0] start,
		input logic [BEAT_W-1:0] beat,
		input logic inter);
		if (inter)
			return start ^ beat; // see [RL9]
		else
			return start + beat; // see [RL8]
	endfunction : f_lo

	assign sel_c = f_sel(s_q.inp);
	assign wmask = f_mask(s_q.inp);
	assign wr_c = (wmask != MASK_NONE); // see [RL12]

	// ============================================================
	// next state: decode the sample taken at the previous edge
	always_comb
	begin
		s_d = s_q;
		// every clocked pin is captured; decisions use the capture
		s_d.inp = '{addr: {address_in, addr_bit1, addr_bit0},
			ps_n: processor_addr_strobe_n,
			cs_n: controller_addr_strobe_n, adv_n: burst_step_n,
			cs1_n: chip_select1_n, dhi: depth_select_hi,
			dlo: depth_select_lo, gw_n: all_byte_write_n,
			bwg_n: byte_write_gate_n, bsel_n: byte_write_select_n,
			din: data_i}; // see [RL1]
		if (sleep_request)
		begin
			// internal clock stopped: burst ended, op back to idle, bus dropped
			s_d.op = SPB_OP_IDLE; // see [RL20]
			s_d.drive = 1'b0;
		end
		else
		begin
			if (!s_q.inp.ps_n && !s_q.inp.cs1_n)
			begin
				// processor strobe reads when selected, otherwise deselects
				s_d.op = sel_c ? SPB_OP_RD : SPB_OP_IDLE; // see [RL5]
				s_d.addr_hi = s_q.inp.addr[ADDR_W-1:BEAT_W]; // see [RL3]
				s_d.start_lo = s_q.inp.addr[BEAT_W-1:0];
				s_d.beat = BEAT_FIRST;
			end
			else if (!s_q.inp.cs_n)
			begin
				if (!sel_c)
					s_d.op = SPB_OP_IDLE; // see [RL4]
				else
					s_d.op = wr_c ? SPB_OP_WR : SPB_OP_RD; // see [RL4]
				s_d.addr_hi = s_q.inp.addr[ADDR_W-1:BEAT_W]; // see [RL3]
				s_d.start_lo = s_q.inp.addr[BEAT_W-1:0];
				s_d.beat = BEAT_FIRST;
			end
			else if (s_q.op != SPB_OP_IDLE && !s_q.inp.adv_n)
			begin
				// two-bit beat wraps; upper bits untouched
				s_d.beat = s_q.beat + BEAT_STEP; // see [RL7] see [RL22]
			end
			// after sleep the op stays idle until a strobe, see [RL21]
			s_d.drive = (s_d.op == SPB_OP_RD); // see [RL18]
		end
	end

	// access of this edge, from the next-state values
	assign acc_rd = !sleep_request && (s_d.op == SPB_OP_RD);
	assign acc_wr = !sleep_request && (s_d.op == SPB_OP_WR);
	assign cur_lo = f_lo(s_q.start_lo, s_q.beat, linear_order_sel);
	assign acc_addr = {s_d.addr_hi,
		f_lo(s_d.start_lo, s_d.beat, linear_order_sel)}; // see [RL2]

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= ST_RST;
		else
			s_q <= s_d;
	end

	// ============================================================
	// write buffer: writes are queued at the edge after the sampling edge and
	// retired into the array on cycles without a read
	spb_wbuf #(
		.WIDTH(WBUF_W),
		.DEPTH(WBUF_DEPTH)
	) u_wbuf (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_valid(acc_wr), // see [RL16]
		.in_ready(write_buf_ready),
		.in_data({acc_addr, wmask, s_q.inp.din}),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	// reads own the array port; sleep stops the drain too
	assign buf_out_ready = !sleep_request && !acc_rd;
	assign drain_addr = buf_out_data[WBUF_W-1 -: ADDR_W];
	assign drain_mask = buf_out_data[DATA_W +: LANES];
	assign drain_data = buf_out_data[DATA_W-1:0];

	// ============================================================
	// array, no reset: contents survive sleep
	always_ff @(posedge clk_sys)
	begin
		if (buf_out_valid && buf_out_ready)
		begin
			for (int l = 0; l < LANES; l++)
			begin
				if (drain_mask[l])
					mem[drain_addr][l*8 +: 8] <= drain_data[l*8 +: 8]; // see [RL14]
			end
		end
	end

	// output register loaded on a read access
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rd_data_q <= DATA_RST;
		else if (acc_rd)
			rd_data_q <= mem[acc_addr]; // see [RL17]
	end

	// ============================================================
	// bus drive: output enable and sleep act without the clock
	assign data_o = rd_data_q;
	assign data_oe_n = !(s_q.drive && !output_enable_n
		&& !sleep_request); // see [RL18]

	// ============================================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	property p_sel_write;
		(!s_q.inp.cs_n && (s_q.inp.ps_n || s_q.inp.cs1_n) && sel_c
			&& wr_c && !sleep_request) |=> (s_q.op == SPB_OP_WR);
	endproperty
	a_sel_write: assert property (p_sel_write) // see [RL12]
		else $error("selected write strobe did not start a write");

	property p_ps_read;
		(!s_q.inp.ps_n && !s_q.inp.cs1_n && sel_c && !sleep_request)
			|=> (s_q.op == SPB_OP_RD) && s_q.drive;
	endproperty
	a_ps_read: assert property (p_ps_read) // see [RL5]
		else $error("processor strobe did not start a read");

	property p_desel;
		(!s_q.inp.cs_n && s_q.inp.cs1_n && !sleep_request)
			|=> (s_q.op == SPB_OP_IDLE) && data_oe_n;
	endproperty
	a_desel: assert property (p_desel) // see [RL4]
		else $error("unselected strobe did not deselect");

	property p_ps_ignored;
		(!s_q.inp.ps_n && s_q.inp.cs1_n && s_q.inp.cs_n && s_q.inp.adv_n
			&& !sleep_request) |=> $stable(s_q.op) && $stable(s_q.beat)
			&& $stable(s_q.addr_hi);
	endproperty
	a_ps_ignored: assert property (p_ps_ignored) // see [RL5]
		else $error("blocked processor strobe changed the cycle");

	property p_advance;
		(s_q.op != SPB_OP_IDLE && s_q.inp.cs_n && s_q.inp.ps_n
			&& !s_q.inp.adv_n && !sleep_request)
			|=> (s_q.beat == $past(s_q.beat) + BEAT_STEP)
			&& $stable(s_q.addr_hi);
	endproperty
	a_advance: assert property (p_advance) // see [RL7]
		else $error("burst did not advance by one beat");

	property p_linear;
		(!linear_order_sel && s_q.op != SPB_OP_IDLE && s_q.inp.cs_n
			&& s_q.inp.ps_n && !s_q.inp.adv_n && !sleep_request)
			##1 !linear_order_sel |-> (cur_lo == $past(cur_lo) + BEAT_STEP);
	endproperty
	a_linear: assert property (p_linear) // see [RL8]
		else $error("linear burst order wrong");

	property p_wrap;
		(s_q.beat == 2'h_3 && s_q.op != SPB_OP_IDLE && s_q.inp.cs_n
			&& s_q.inp.ps_n && !s_q.inp.adv_n && !sleep_request)
			|=> (s_q.beat == BEAT_FIRST);
	endproperty
	a_wrap: assert property (p_wrap) // see [RL22]
		else $error("burst counter did not wrap after four beats");

	property p_gw_all;
		(acc_wr && !s_q.inp.gw_n) |-> (wmask == MASK_ALL);
	endproperty
	a_gw_all: assert property (p_gw_all) // see [RL13]
		else $error("global write did not select all lanes");

	property p_float;
		(output_enable_n || sleep_request || (s_q.op == SPB_OP_WR))
			|-> data_oe_n;
	endproperty
	a_float: assert property (p_float) // see [RL18]
		else $error("bus driven while it must float");

	property p_sleep_idle;
		sleep_request |=> (s_q.op == SPB_OP_IDLE) && !s_q.drive;
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) // see [RL20]
		else $error("sleep did not stop the burst");

	property p_wake_idle;
		(s_q.op == SPB_OP_IDLE && s_q.inp.cs_n && s_q.inp.ps_n)
			|=> (s_q.op == SPB_OP_IDLE);
	endproperty
	a_wake_idle: assert property (p_wake_idle) // see [RL21]
		else $error("left low power without a strobe");

	c_read_burst: cover property ((s_q.op == SPB_OP_RD) && !data_oe_n [*4]);
	c_write: cover property (acc_wr ##1 acc_wr);
	c_sleep_wake: cover property (sleep_request ##1 !sleep_request ##[1:8]
		(s_q.op == SPB_OP_RD));
	c_write_held: cover property (buf_out_valid && !buf_out_ready);
endmodule : spb_port

// file: dv/spb_host.sv
`timescale 1ns/1ps
// ============================================================
// host side of the data bus: drives write data, else floats
module spb_host
(
	input wire logic clk_sys, // system clock
	input wire logic drive, // host drives write data
	input wire logic [31:0] wdata, // write data from host
	input wire logic [31:0] data_o, // device bus value
	input wire logic data_oe_n, // device drives when low
	output logic [31:0] data_i // resolved bus level
);
	logic [31:0] junk_q = 32'h_5A5A_5A5A;

	// an undriven bus shows a pattern that changes every cycle
	always_ff @(posedge clk_sys)
		junk_q <= ~junk_q;

	// bus resolution; the host only drives while output enable is raised
	always_comb
	begin
		if (!data_oe_n)
			data_i = data_o;
		else if (drive)
			data_i = wdata;
		else
			data_i = junk_q;
	end
endmodule : spb_host

// file: dv/tb_spb_port.sv
`timescale 1ns/1ps
// ============================================================
// bench for the burst sram port
module tb_spb_port
	import spb_pkg::*;
;
	logic clk_sys = 1'h0, rst_b = 1'h0, addr_bit1 = 1'h0, addr_bit0 = 1'h0;
	logic ps_n = 1, cs_n = 1, adv_n = 1, cs1_n = 1, dhi = 0, dlo = 1;
	logic gw_n = 1, bwg_n = 1, oe_n = 1, lin = 1, zz = 0, drive = 0;
	logic [HI_W-1:0] address_in = '0, hs, hm;
	logic [LANES-1:0] bsel_n = MASK_ALL;
	logic [DATA_W-1:0] wdata = DATA_RST, data_i, data_o;
	logic data_oe_n, write_buf_ready;
	logic [1:0] st, bt;
	logic [DATA_W-1:0] mem[int];
	bit q_r[$];
	logic [DATA_W-1:0] q_v[$];
	int n_fail = 0, num_checks = 0, op = 0, seed = 32'h_0000_4106;

	// 10 MHz system clock
	always #50 clk_sys = ~clk_sys;

	spb_port i_spb_port (.clk_sys(clk_sys), .rst_b(rst_b),
		.address_in(address_in), .addr_bit1(addr_bit1),
		.addr_bit0(addr_bit0), .processor_addr_strobe_n(ps_n),
		.controller_addr_strobe_n(cs_n), .burst_step_n(adv_n),
		.chip_select1_n(cs1_n), .depth_select_hi(dhi),
		.depth_select_lo(dlo), .all_byte_write_n(gw_n),
		.byte_write_gate_n(bwg_n), .byte_write_select_n(bsel_n),
		.output_enable_n(oe_n), .linear_order_sel(lin),
		.sleep_request(zz), .data_i(data_i), .data_o(data_o),
		.data_oe_n(data_oe_n), .write_buf_ready(write_buf_ready));
	spb_host i_spb_host (.clk_sys(clk_sys), .drive(drive),
		.wdata(wdata), .data_o(data_o), .data_oe_n(data_oe_n),
		.data_i(data_i));

	// ============================================================
	// checking and closing
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic close_out();
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// one pin cycle: judge the cycle two back, then model this one
	task automatic tick();
		logic [16:0] a;
		logic [3:0] m;
		bit w;
		#1;
		if (q_r.size() == 2)
		begin
			if (q_r[0] && !oe_n && !zz)
				chk(data_o, q_v[0]);
			chk(data_oe_n, !(q_r[0] && !oe_n && !zz));
			void'(q_r.pop_front());
			void'(q_v.pop_front());
		end
		chk(write_buf_ready, 1'h1);
		m = !gw_n ? MASK_ALL : (!bwg_n ? ~bsel_n : MASK_NONE);
		w = (m != MASK_NONE);
		if (zz)
			op = 0;
		else if (!ps_n && !cs1_n || !cs_n)
		begin
			hm = address_in;
			st = {addr_bit1, addr_bit0};
			bt = BEAT_FIRST;
			op = (!cs1_n && dhi && !dlo) ? ((w && ps_n) ? 2 : 1) : 0;
		end
		else if (op != 0 && !adv_n)
			bt = bt + BEAT_STEP;
		a = {hm, lin ? st ^ bt : st + bt};
		if (op == 2)
			for (int i = 0; i < LANES; i++)
				if (m[i])
					mem[a][8*i +: 8] = wdata[8*i +: 8];
		q_r.push_back(op == 1);
		q_v.push_back((op == 1 && mem.exists(a)) ? mem[a] : DATA_RST);
		@(posedge clk_sys);
		#1;
	endtask : tick

	// ============================================================
	// stimulus: one burst, strobe beat first, then n-1 advance beats
	task automatic burst(input bit ps, input logic [1:0] lo, input int n,
		input logic g, input logic bg, input logic [3:0] sn);
		for (int i = 0; i < n; i++)
		begin
			cs_n = ps || i != 0;
			adv_n = (i == 0);
			{cs1_n, dhi, dlo} = (i == 0) ? 3'h2 : 3'($random(seed));
			// stray processor strobe only while select is high
			ps_n = (i == 0) ? !ps : (!cs1_n || $random(seed) & 1);
			address_in = (i == 0) ? hs : 15'($random(seed));
			{addr_bit1, addr_bit0} = (i == 0) ? lo : 2'($random(seed));
			gw_n = g;
			bwg_n = bg;
			bsel_n = sn;
			oe_n = (!g || !bg && sn != MASK_ALL) && !ps;
			drive = oe_n;
			wdata = $random(seed);
			tick();
		end
	endtask : burst

	// pins at rest; a read in progress stays on or steps its address
	task automatic idle(input int n, input logic o, input logic ad);
		repeat (n)
		begin
			{ps_n, cs_n, adv_n, gw_n, bwg_n, oe_n, drive} =
				{2'h3, ad, 2'h3, o, 1'h0};
			tick();
		end
	endtask : idle

	// ============================================================
	// main sequence
	initial
	begin
		repeat (16) @(posedge clk_sys);
		#1;
		rst_b = 1'h1;
		@(posedge clk_sys);
		#1;
		hs = 15'($random(seed));
		lin = 1'h0;
		burst(0, 2'h1, 4, 1'h0, 1'h1, MASK_ALL);
		idle(6, 1'h1, 1'h1);
		for (int i = 0; i < LANES; i++)
			burst(0, 2'(i), 1, 1'h1, 1'h0, ~(4'h1 << i));
		idle(6, 1'h1, 1'h1);
		burst(0, 2'h2, 1, 1'h1, 1'h0, MASK_ALL);
		burst(0, 2'h1, 5, 1'h1, 1'h1, MASK_ALL);
		lin = 1'h1;
		burst(1, 2'h2, 5, 1'h0, 1'h0, MASK_NONE);
		idle(2, 1'h0, 1'h1);
		idle(1, 1'h1, 1'h0);
		burst(0, 2'h3, 1, 1'h0, 1'h1, MASK_ALL);
		idle(3, 1'h1, 1'h1);
		burst(0, 2'h3, 1, 1'h1, 1'h1, MASK_ALL);
		idle(2, 1'h0, 1'h1);
		// every select pattern behind either strobe
		for (int i = 0; i < 16; i++)
		begin
			burst(0, 2'h0, 1, 1'h1, 1'h1, MASK_ALL);
			{cs1_n, dhi, dlo} = i[2:0];
			ps_n = !i[3];
			cs_n = i[3];
			tick();
			idle(2, 1'h0, 1'h1);
		end
		// sleep in mid-burst, then advances must not restart it
		burst(0, 2'h1, 2, 1'h1, 1'h1, MASK_ALL);
		zz = 1'h1;
		idle(4, 1'h0, 1'h0);
		zz = 1'h0;
		idle(4, 1'h0, 1'h0);
		burst(0, 2'h1, 4, 1'h1, 1'h1, MASK_ALL);
		idle(3, 1'h0, 1'h1);
		// each write is held in the buffer while the next read owns the array
		for (int i = 0; i < LANES; i++)
		begin
			burst(0, 2'(i), 1, 1'h0, 1'h1, MASK_ALL);
			burst(0, 2'(i + 1), 1, 1'h1, 1'h1, MASK_ALL);
		end
		// a write cycle lets the last held entry drain, then read all back
		burst(0, 2'h2, 1, 1'h0, 1'h1, MASK_ALL);
		idle(2, 1'h1, 1'h1);
		burst(0, 2'h0, 4, 1'h1, 1'h1, MASK_ALL);
		idle(3, 1'h0, 1'h1);
		// output enable and sleep float the bus without a clock edge
		chk(data_oe_n, 1'h0);
		chk(data_i, data_o);
		oe_n = 1'h1;
		#1;
		chk(data_oe_n, 1'h1);
		oe_n = 1'h0;
		zz = 1'h1;
		#1;
		chk(data_oe_n, 1'h1);
		zz = 1'h0;
		#1;
		chk(data_oe_n, 1'h0);
		close_out();
	end

	// watchdog: the whole run needs well under a millisecond
	initial
	begin
		#1_000_000;
		n_fail++;
		close_out();
	end
endmodule : tb_spb_port
